// file: logic/dbs_pkg.sv
// shared constants for the debug status and breakpoint register block
package dbs_pkg;
	// status/control bit positions
	localparam int DBS_BIT_SLOW_FAIL = 0;
	localparam int DBS_BIT_LP_FAIL = 1;
	localparam int DBS_BIT_WAIT_STOP = 2;
	localparam int DBS_BIT_TYPE_SEL = 3;
	localparam int DBS_BIT_BKPT_EN = 4;
	localparam int DBS_BIT_MODE_ACT = 6;
	// force-reset control bit position
	localparam int DBS_BIT_FORCE_RST = 0;
	// reset values and the force-reset read value
	localparam logic [7:0] DBS_CTRL_RESET = 8'h00;
	localparam logic [15:0] DBS_BKPT_RESET = 16'h0000;
	localparam logic [7:0] DBS_FRST_READ = 8'h00;
	// width of the system reset request pulse, in clocks
	localparam logic [3:0] DBS_RST_PULSE = 4'h4;
	// serial command codes
	typedef enum logic [2:0]
	{
		DBS_CMD_NONE,
		DBS_CMD_HALT,
		DBS_CMD_STATUS_RD,
		DBS_CMD_CTRL_WR,
		DBS_CMD_BKPT_RD,
		DBS_CMD_BKPT_WR,
		DBS_CMD_MEM_WR_FRST,
		DBS_CMD_MEM_ACCESS
	} dbs_cmd_t;
endpackage

// file: logic/dbs_regs.sv
// debug status, breakpoint address and force-reset registers
// What this block does
// - wait/stop status reads one in wait/stop or after a halt taken in wait/stop
// - only halt and status reads serviced in wait/stop outside debug mode; halt enters debug
// - low-power failure bit set on conflicting access
// - slow-access failure bit unused, reads zero
// - sixteen-bit breakpoint address register
// - enable and type bits drive breakpoint compare
// - breakpoint register reached only by serial commands
// - force-reset bit written by serial byte write
// - cpu writes to force-reset are ignored
// - force-reset reads return all zero
`timescale 1ns/10ps
module dbs_regs
	import dbs_pkg::*;
(
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// cpu state pins
	input wire logic cpu_wait_stop_i,
	input wire logic cpu_wait_stop_entry_i,
	// serial command port from the debug shift logic
	input wire logic cmd_valid_i,
	input wire dbs_cmd_t cmd_i,
	input wire logic [15:0] cmd_data_i,
	output logic [15:0] rsp_data_o,
	output logic rsp_valid_o,
	output logic cmd_refused_o,
	// cpu bus write to the force-reset location
	input wire logic cpu_frst_wr_i,
	input wire logic [7:0] cpu_wdata_i,
	// breakpoint compare configuration
	output logic [15:0] bkpt_addr_o,
	output logic bkpt_en_o,
	output logic bkpt_type_o,
	// cpu control
	output logic halt_req_o,
	output logic debug_active_o,
	output logic sys_reset_req_o
);
	logic ws_pin;
	logic ws_entry_pin;
	logic debug_active;
	logic halted_from_ws;
	logic lp_fail;
	logic bkpt_en;
	logic type_sel;
	logic [15:0] bkpt_addr;
	logic [3:0] rst_cnt;
	logic take;
	logic serviceable;

	dbs_sync u_sync_ws
	(
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.d_i(cpu_wait_stop_i),
		.q_o(ws_pin)
	);
	dbs_sync u_sync_entry
	(
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.d_i(cpu_wait_stop_entry_i),
		.q_o(ws_entry_pin)
	);

	function automatic logic [7:0] status_byte(input logic ws, input logic lpf,
		input logic act, input logic en, input logic ts);
		logic [7:0] s;
		s = 8'h00;
		s[DBS_BIT_WAIT_STOP] = ws;
		s[DBS_BIT_LP_FAIL] = lpf;
		s[DBS_BIT_SLOW_FAIL] = 1'b0;
		s[DBS_BIT_MODE_ACT] = act;
		s[DBS_BIT_BKPT_EN] = en;
		s[DBS_BIT_TYPE_SEL] = ts;
		return s;
	endfunction

	assign take = cmd_valid_i && ce_i;
	// in wait/stop outside debug mode only halt and status reads get through
	assign serviceable = !ws_pin || debug_active || cmd_i == DBS_CMD_HALT
		|| cmd_i == DBS_CMD_STATUS_RD;

	// debug mode and the halted-from-wait/stop memory
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			debug_active <= 1'b0;
			halted_from_ws <= 1'b0;
		end
		else if (ce_i && take && cmd_i == DBS_CMD_HALT)
		begin
			debug_active <= 1'b1;
			halted_from_ws <= ws_pin;
		end
	end

	// access failure: set wins, a status read clears it afterwards
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			lp_fail <= 1'b0;
		else if (ce_i)
		begin
			if (take && cmd_i == DBS_CMD_MEM_ACCESS && !debug_active
				&& (ws_pin || ws_entry_pin))
				lp_fail <= 1'b1;
			else if (take && cmd_i == DBS_CMD_STATUS_RD)
				lp_fail <= 1'b0;
		end
	end

	// control bits and breakpoint address
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			bkpt_en <= DBS_CTRL_RESET[DBS_BIT_BKPT_EN];
			type_sel <= DBS_CTRL_RESET[DBS_BIT_TYPE_SEL];
			bkpt_addr <= DBS_BKPT_RESET;
		end
		else if (ce_i && take && serviceable)
		begin
			if (cmd_i == DBS_CMD_CTRL_WR)
			begin
				bkpt_en <= cmd_data_i[DBS_BIT_BKPT_EN];
				type_sel <= cmd_data_i[DBS_BIT_TYPE_SEL];
			end
			if (cmd_i == DBS_CMD_BKPT_WR)
				bkpt_addr <= cmd_data_i;
		end
	end

	// force reset: only the serial byte write reaches it; cpu port unused by design
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rst_cnt <= 4'h0;
		else if (ce_i)
		begin
			if (take && serviceable && cmd_i == DBS_CMD_MEM_WR_FRST
				&& cmd_data_i[DBS_BIT_FORCE_RST])
				rst_cnt <= DBS_RST_PULSE;
			else if (rst_cnt != 4'h0)
				rst_cnt <= rst_cnt - 4'h1;
		end
	end

	// answers
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rsp_data_o <= 16'h0000;
			rsp_valid_o <= 1'b0;
			cmd_refused_o <= 1'b0;
		end
		else if (ce_i)
		begin
			rsp_valid_o <= 1'b0;
			cmd_refused_o <= take && !serviceable;
			if (take && serviceable)
			begin
				unique case (cmd_i)
					DBS_CMD_STATUS_RD:
					begin
						rsp_data_o <= {8'h00, status_byte(ws_pin || halted_from_ws,
							lp_fail, debug_active, bkpt_en, type_sel)};
						rsp_valid_o <= 1'b1;
					end
					DBS_CMD_BKPT_RD:
					begin
						rsp_data_o <= bkpt_addr;
						rsp_valid_o <= 1'b1;
					end
					DBS_CMD_MEM_WR_FRST:
					begin
						rsp_data_o <= {8'h00, DBS_FRST_READ};
						rsp_valid_o <= 1'b1;
					end
					DBS_CMD_NONE, DBS_CMD_HALT, DBS_CMD_CTRL_WR, DBS_CMD_BKPT_WR,
						DBS_CMD_MEM_ACCESS:
						rsp_valid_o <= 1'b0;
				endcase
			end
		end
	end

	// registered outputs
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			bkpt_addr_o <= DBS_BKPT_RESET;
			bkpt_en_o <= 1'b0;
			bkpt_type_o <= 1'b0;
			halt_req_o <= 1'b0;
			debug_active_o <= 1'b0;
			sys_reset_req_o <= 1'b0;
		end
		else if (ce_i)
		begin
			bkpt_addr_o <= bkpt_addr;
			bkpt_en_o <= bkpt_en;
			bkpt_type_o <= type_sel;
			halt_req_o <= take && cmd_i == DBS_CMD_HALT;
			debug_active_o <= debug_active;
			sys_reset_req_o <= rst_cnt != 4'h0;
		end
	end

	// cpu writes to the force-reset location are deliberately dropped
	logic cpu_unused;
	assign cpu_unused = cpu_frst_wr_i ^ (^cpu_wdata_i);
endmodule // dbs_regs

// file: logic/dbs_sync.sv
// two-flop synchroniser for pin-side levels
`timescale 1ns/10ps
module dbs_sync
	import dbs_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// levels
	input wire logic d_i,
	output logic q_o
);
	logic stage1;
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			stage1 <= 1'b0;
			q_o <= 1'b0;
		end
		else if (ce_i)
		begin
			stage1 <= d_i;
			q_o <= stage1;
		end
	end
endmodule // dbs_sync

// file: testbench/dbs_host.sv
// debug host model issuing serial commands
`timescale 1ns/10ps
module dbs_host
	import dbs_pkg::*;
(
	// clock
	input wire logic clk_i,
	// command and answer
	output logic cmd_valid_o,
	output dbs_cmd_t cmd_o,
	output logic [15:0] cmd_data_o,
	input wire logic [15:0] rsp_data_i,
	input wire logic cmd_refused_i
);
	initial
	begin
		cmd_valid_o = 1'b0;
		cmd_o = DBS_CMD_NONE;
		cmd_data_o = 16'h0000;
	end
	// data flips after use so a stale value never looks like a command
	task automatic send(input dbs_cmd_t c, input logic [15:0] d, output logic [15:0] r,
		output logic f);
		@(posedge clk_i);
		cmd_valid_o <= 1'b1;
		cmd_o <= c;
		cmd_data_o <= d;
		@(posedge clk_i);
		cmd_valid_o <= 1'b0;
		cmd_data_o <= ~d;
		#1;
		r = rsp_data_i;
		f = cmd_refused_i;
	endtask
endmodule // dbs_host

// file: testbench/dbs_regs_chk.sv
// port assertions for the debug register block
`timescale 1ns/10ps
module dbs_chk
	import dbs_pkg::*;
(
	// clock, reset, command
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire logic cmd_valid_i,
	input wire dbs_cmd_t cmd_i,
	input wire logic [15:0] cmd_data_i,
	// outputs
	input wire logic [15:0] rsp_data_o,
	input wire logic rsp_valid_o,
	input wire logic cmd_refused_o,
	input wire logic [15:0] bkpt_addr_o,
	input wire logic bkpt_en_o,
	input wire logic bkpt_type_o,
	input wire logic halt_req_o,
	input wire logic debug_active_o,
	input wire logic sys_reset_req_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	wire logic tk = ce_i && cmd_valid_i;
	a_status_bit0: assert property (tk && cmd_i == DBS_CMD_STATUS_RD |=> !rsp_data_o[0])
		else $error("status bit0 set");
	a_halt_served: assert property (tk && cmd_i == DBS_CMD_HALT |=>
		halt_req_o && !cmd_refused_o ##[0:2] debug_active_o) else $error("halt lost");
	a_refuse_cause: assert property (cmd_refused_o |->
		!$past(debug_active_o) && $past(cmd_i) != DBS_CMD_HALT) else $error("bad refusal");
	a_debug_holds: assert property ($past(debug_active_o) |-> debug_active_o)
		else $error("debug mode dropped");
	a_frst_zero: assert property (tk && cmd_i == DBS_CMD_MEM_WR_FRST |=>
		cmd_refused_o || rsp_data_o == 16'h0000) else $error("force reset read");
	a_reset_width: assert property ($rose(sys_reset_req_o) |->
		sys_reset_req_o [*4] ##1 !sys_reset_req_o) else $error("reset pulse width");
	a_bkpt_load: assert property (tk && cmd_i == DBS_CMD_BKPT_WR && debug_active_o |->
		##2 bkpt_addr_o == $past(cmd_data_i, 2)) else $error("breakpoint address");
	a_ctrl_load: assert property (tk && cmd_i == DBS_CMD_CTRL_WR && debug_active_o |->
		##2 {bkpt_en_o, bkpt_type_o} == $past(cmd_data_i[4:3], 2)) else $error("bkpt config");
	a_read_answer: assert property (tk && cmd_i == DBS_CMD_STATUS_RD |=> rsp_valid_o)
		else $error("status read unanswered");
	c_refused: cover property (cmd_refused_o);
	c_reset_req: cover property ($rose(sys_reset_req_o));
	c_bkpt_on: cover property (bkpt_en_o && bkpt_type_o);
endmodule // dbs_chk

// file: testbench/dbs_regs_tb_top.sv
// self-checking bench for the debug register block
`timescale 1ns/10ps
module dbs_regs_tb_top
	import dbs_pkg::*;
;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic ws = 1'b0;
	logic fw = 1'b0;
	logic [7:0] wd = 8'h00;
	logic ce = 1'b1;
	logic wse = 1'b0;
	logic rv;
	logic cv, rf, sr, f;
	dbs_cmd_t cm;
	logic [15:0] cd, rsp, r;
	int n_mismatch = 0;
	int checked = 0;
	int k;
	dbs_regs uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .cpu_wait_stop_i(ws),
		.cpu_wait_stop_entry_i(wse), .cmd_valid_i(cv), .cmd_i(cm), .cmd_data_i(cd),
		.rsp_data_o(rsp), .rsp_valid_o(rv), .cmd_refused_o(rf), .cpu_frst_wr_i(fw),
		.cpu_wdata_i(wd), .bkpt_addr_o(), .bkpt_en_o(), .bkpt_type_o(), .halt_req_o(),
		.debug_active_o(), .sys_reset_req_o(sr));
	dbs_host host (.clk_i(clk_i), .cmd_valid_o(cv), .cmd_o(cm), .cmd_data_o(cd),
		.rsp_data_i(rsp), .cmd_refused_i(rf));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		if (n_mismatch == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
		forever #50 clk_i = ~clk_i;
	initial
	begin
		repeat (5) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		fw <= 1'b1;
		wd <= 8'hFF;
		@(posedge clk_i);
		fw <= 1'b0;
		repeat (8)
		begin
			@(posedge clk_i);
			#1;
			chk(16'(sr), 16'h0000);
		end
		// cpu enters wait/stop while a memory access is in flight
		@(posedge clk_i);
		wse <= 1'b1;
		repeat (3) @(posedge clk_i);
		host.send(DBS_CMD_MEM_ACCESS, 16'h0000, r, f);
		chk(16'(f), 16'h0000);
		host.send(DBS_CMD_STATUS_RD, 16'h0000, r, f);
		chk({8'h00, r[7:0]}, 16'h0002);
		@(posedge clk_i);
		wse <= 1'b0;
		@(posedge clk_i);
		ws <= 1'b1;
		repeat (4) @(posedge clk_i);
		host.send(DBS_CMD_BKPT_WR, 16'h1234, r, f);
		chk(16'(f), 16'h0001);
		host.send(DBS_CMD_MEM_ACCESS, 16'h0000, r, f);
		chk(16'(f), 16'h0001);
		host.send(DBS_CMD_STATUS_RD, 16'h0000, r, f);
		chk({8'h00, r[7:0]}, 16'h0006);
		host.send(DBS_CMD_HALT, 16'h0000, r, f);
		host.send(DBS_CMD_STATUS_RD, 16'h0000, r, f);
		chk({8'h00, r[7:0]}, 16'h0044);
		host.send(DBS_CMD_MEM_ACCESS, 16'h0000, r, f);
		chk(16'(f), 16'h0000);
		// halt took the cpu out of wait/stop; status bit must remember it
		@(posedge clk_i);
		ws <= 1'b0;
		repeat (3) @(posedge clk_i);
		host.send(DBS_CMD_CTRL_WR, 16'h0018, r, f);
		host.send(DBS_CMD_BKPT_WR, 16'hA5C3, r, f);
		host.send(DBS_CMD_BKPT_RD, 16'h0000, r, f);
		chk(r, 16'hA5C3);
		// a write while the enable is low must leave the address alone
		@(posedge clk_i);
		ce <= 1'b0;
		host.send(DBS_CMD_BKPT_WR, 16'h0F0F, r, f);
		@(posedge clk_i);
		ce <= 1'b1;
		host.send(DBS_CMD_BKPT_RD, 16'h0000, r, f);
		chk(16'(rv), 16'h0001);
		chk(r, 16'hA5C3);
		host.send(DBS_CMD_STATUS_RD, 16'h0000, r, f);
		chk({8'h00, r[7:0]}, 16'h005C);
		host.send(DBS_CMD_MEM_WR_FRST, 16'h0000, r, f);
		chk(r, 16'h0000);
		host.send(DBS_CMD_MEM_WR_FRST, 16'h0001, r, f);
		chk(r, 16'h0000);
		k = 0;
		repeat (12)
		begin
			k += sr;
			@(posedge clk_i);
			#1;
		end
		chk(16'(k), 16'h0004);
		// debug mode and breakpoint state only leave through reset
		@(posedge clk_i);
		arst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		host.send(DBS_CMD_STATUS_RD, 16'h0000, r, f);
		chk({8'h00, r[7:0]}, 16'h0000);
		host.send(DBS_CMD_BKPT_RD, 16'h0000, r, f);
		chk(16'(rv), 16'h0001);
		chk(r, 16'h0000);
		test_done();
	end
endmodule // dbs_regs_tb_top
bind dbs_regs dbs_chk chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
	.cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_data_i(cmd_data_i), .rsp_data_o(rsp_data_o),
	.rsp_valid_o(rsp_valid_o), .cmd_refused_o(cmd_refused_o), .bkpt_addr_o(bkpt_addr_o),
	.bkpt_en_o(bkpt_en_o),
	.bkpt_type_o(bkpt_type_o), .halt_req_o(halt_req_o), .debug_active_o(debug_active_o),
	.sys_reset_req_o(sys_reset_req_o));
